/* css_mst.sv */
`timescale 1ns/1ps
`default_nettype none

// bus master model, open drain: a 1 releases the line
module css_mst (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  // both lines rest released between frames
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  // a quarter bit is 16 ns, so a bit takes 64 ns
  task automatic qtr();
    repeat (4) @(posedge clk_in);
  endtask : qtr

  // one clock pulse: data set while low, sampled while high
  task automatic bit_io(input logic b, output logic s);
    qtr();
    sda_out <= b;
    qtr();
    scl_out <= 1'b1;
    qtr();
    s = sda_in;
    qtr();
    scl_out <= 1'b0;
  endtask : bit_io

  // start, or repeated start from a low clock
  task automatic start();
    qtr();
    sda_out <= 1'b1;
    qtr();
    scl_out <= 1'b1;
    qtr();
    sda_out <= 1'b0;
    qtr();
    scl_out <= 1'b0;
  endtask : start

  // stop: data rises while the clock is high
  task automatic stop();
    qtr();
    sda_out <= 1'b0;
    qtr();
    scl_out <= 1'b1;
    qtr();
    sda_out <= 1'b1;
    qtr();
  endtask : stop

  // send a byte msb first, return the acknowledge
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : wr_byte

  // take a byte, answer not-acknowledge when last is set
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(last, s);
  endtask : rd_byte
endmodule : css_mst

`default_nettype wire

/* css_pkg.sv */
`default_nettype none

package css_pkg;

  // fixed seven-bit bus address of this slave
  localparam logic [6:0] OWN_ADDR = 7'h74;

  // capacitor count registers, one byte each
  localparam logic [7:0] RED_CAP_OFS = 8'h06;
  localparam logic [7:0] GREEN_CAP_OFS = 8'h07;
  localparam logic [7:0] BLUE_CAP_OFS = 8'h08;
  localparam logic [7:0] CLEAR_CAP_OFS = 8'h09;

  // integration slot registers, low byte here, upper bits one address up
  localparam logic [7:0] RED_INT_OFS = 8'h0A;
  localparam logic [7:0] GREEN_INT_OFS = 8'h0C;
  localparam logic [7:0] BLUE_INT_OFS = 8'h0E;
  localparam logic [7:0] CLEAR_INT_OFS = 8'h10;
  localparam logic [7:0] HIGH_BYTE_STEP = 8'h01;

  // field widths and values after reset
  localparam int CAP_W = 4;
  localparam int INT_W = 12;
  localparam logic [3:0] CAP_RESET = 4'hF;
  localparam logic [11:0] INT_RESET = 12'h000;

  // bits in one serial byte, acknowledge excluded
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // serial engine states, one-hot
  typedef enum logic [8:0] {
    ST_IDLE     = 9'b0_0000_0001,
    ST_ADDR     = 9'b0_0000_0010,
    ST_ADDR_ACK = 9'b0_0000_0100,
    ST_REG      = 9'b0_0000_1000,
    ST_REG_ACK  = 9'b0_0001_0000,
    ST_WDATA    = 9'b0_0010_0000,
    ST_WACK     = 9'b0_0100_0000,
    ST_RDATA    = 9'b0_1000_0000,
    ST_RACK     = 9'b1_0000_0000
  } css_state_t;

endpackage : css_pkg

`default_nettype wire

/* css_regfile.sv */
`timescale 1ns/1ps
`default_nettype none

module css_regfile
  import css_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out,
  output logic [CAP_W-1:0] red_cap_out,
  output logic [CAP_W-1:0] green_cap_out,
  output logic [CAP_W-1:0] blue_cap_out,
  output logic [CAP_W-1:0] clear_cap_out,
  output logic [INT_W-1:0] red_int_out,
  output logic [INT_W-1:0] green_int_out,
  output logic [INT_W-1:0] blue_int_out,
  output logic [INT_W-1:0] clear_int_out
);

  // capacitor byte decode: {hit, channel}
  function automatic logic [2:0] cap_sel(input logic [7:0] a);
    case (a)
      RED_CAP_OFS: cap_sel = 3'b100;
      GREEN_CAP_OFS: cap_sel = 3'b101;
      BLUE_CAP_OFS: cap_sel = 3'b110;
      CLEAR_CAP_OFS: cap_sel = 3'b111;
      default: cap_sel = 3'b000;
    endcase
  endfunction : cap_sel

  // integration byte decode: {hit, high byte, channel}
  function automatic logic [3:0] int_sel(input logic [7:0] a);
    case (a)
      RED_INT_OFS: int_sel = 4'b1000;
      GREEN_INT_OFS: int_sel = 4'b1001;
      BLUE_INT_OFS: int_sel = 4'b1010;
      CLEAR_INT_OFS: int_sel = 4'b1011;
      RED_INT_OFS + HIGH_BYTE_STEP: int_sel = 4'b1100;
      GREEN_INT_OFS + HIGH_BYTE_STEP: int_sel = 4'b1101;
      BLUE_INT_OFS + HIGH_BYTE_STEP: int_sel = 4'b1110;
      CLEAR_INT_OFS + HIGH_BYTE_STEP: int_sel = 4'b1111;
      default: int_sel = 4'b0000;
    endcase
  endfunction : int_sel

  logic [CAP_W-1:0] cap_reg [4]; // capacitor counts per channel
  logic [INT_W-1:0] int_reg [4]; // integration slot counts per channel
  logic [7:0] rdata_reg; // registered read byte
  wire logic [2:0] csel = cap_sel(addr_in); // decoded capacitor target
  wire logic [3:0] isel = int_sel(addr_in); // decoded integration target
  wire logic [INT_W-1:0] isel_val = int_reg[isel[1:0]]; // addressed slot count
  wire logic [7:0] rd_value = csel[2] ? {4'h0, cap_reg[csel[1:0]]} :
                              !isel[3] ? 8'h00 :
                              isel[2] ? {4'h0, isel_val[11:8]} : isel_val[7:0];

  // register storage, cleared to defaults by reset
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < 4; i++) begin
        cap_reg[i] <= CAP_RESET;
        int_reg[i] <= INT_RESET;
      end
    end else if (wr_en_in) begin
      // capacitor byte: low nibble kept, upper bits read zero
      if (csel[2]) begin
        cap_reg[csel[1:0]] <= wdata_in[3:0];
      end
      // slot count: low byte or upper nibble
      if (isel[3] && isel[2]) begin
        int_reg[isel[1:0]][11:8] <= wdata_in[3:0];
      end else if (isel[3]) begin
        int_reg[isel[1:0]][7:0] <= wdata_in;
      end
    end
  end

  // read byte follows the address one cycle later
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rd_value;
    end
  end

  assign rdata_out = rdata_reg;
  assign red_cap_out = cap_reg[0];
  assign green_cap_out = cap_reg[1];
  assign blue_cap_out = cap_reg[2];
  assign clear_cap_out = cap_reg[3];
  assign red_int_out = int_reg[0];
  assign green_int_out = int_reg[1];
  assign blue_int_out = int_reg[2];
  assign clear_int_out = int_reg[3];

endmodule : css_regfile

`default_nettype wire

/* css_slave.sv */
// What this block does
// - idle bus: both lines released high
// - slave transceiver only, up to 100 kbit/s
// - detect start: data falls, clock high
// - detect stop: data rises, clock high; idle
// - busy start to stop; restart equals start
// - change data only while clock low
// - drive data only for ack or read
// - eight bits msb first, then ack bit
// - every received byte acknowledged by receiver
// - master nack ends reading; release data line
// - first byte: seven-bit address, direction bit
// - matching address acked; direction sets role
// - answer only the fixed own address
// - write: address, register, data, then store
// - read: pointer write, restart, send register byte
// - functions as individually addressed byte registers
// - capacitor counts at addresses six to nine
// - slot counts at A, C, E, 10
// - slot counts zero to FFF, reset zero
// - capacitor counts zero to 15, reset 0F
// - reset sets all registers to defaults asynchronously
// - sleep halts core and powers analog down
`timescale 1ns/1ps
`default_nettype none

module css_slave
  import css_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sleep_in,
  input wire logic bus_clock_pin_in,
  input wire logic bus_data_pin_in,
  output logic bus_data_pin_out,
  output logic bus_data_pin_oe_out,
  output logic bus_busy_out,
  output logic analog_power_down_out,
  output logic [CAP_W-1:0] red_capacitor_count_out,
  output logic [CAP_W-1:0] green_capacitor_count_out,
  output logic [CAP_W-1:0] blue_capacitor_count_out,
  output logic [CAP_W-1:0] clear_capacitor_count_out,
  output logic [INT_W-1:0] red_integration_slots_out,
  output logic [INT_W-1:0] green_integration_slots_out,
  output logic [INT_W-1:0] blue_integration_slots_out,
  output logic [INT_W-1:0] clear_integration_slots_out
);

  // synchroniser stages: first stage feeds only the second
  logic scl_meta_reg; // clock pin, first stage
  logic scl_sync_reg; // clock pin, settled
  logic scl_prev_reg; // clock pin, one cycle older
  logic sda_meta_reg; // data pin, first stage
  logic sda_sync_reg; // data pin, settled
  logic sda_prev_reg; // data pin, one cycle older
  logic slp_meta_reg; // sleep pin, first stage
  logic slp_sync_reg; // sleep pin, settled

  // serial engine state
  css_state_t state_reg; // current state
  css_state_t state_next; // next state
  logic [3:0] bit_cnt_reg; // bits seen in current byte
  logic [3:0] bit_cnt_next;
  logic [7:0] rx_shift_reg; // received bits, msb first
  logic [7:0] rx_shift_next;
  logic [7:0] tx_shift_reg; // bits still to send, msb at top
  logic [7:0] tx_shift_next;
  logic [7:0] reg_ptr_reg; // register pointer
  logic [7:0] reg_ptr_next;
  logic master_ack_reg; // master acknowledged last read byte
  logic master_ack_next;
  logic drive_low_reg; // pulls the data line low
  logic drive_low_next;
  logic busy_reg; // bus held between start and stop
  logic busy_next;
  logic wr_en_reg; // one-cycle store strobe
  logic wr_en_next;
  logic [7:0] wr_data_reg; // byte to store
  logic [7:0] wr_data_next;
  logic pd_reg; // analog power down

  // register file read byte at the pointer
  logic [7:0] rf_rdata;

  // bus events seen on the settled samples
  wire logic scl_rise = scl_sync_reg & ~scl_prev_reg;
  wire logic scl_fall = ~scl_sync_reg & scl_prev_reg;
  wire logic start_seen = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
  wire logic stop_seen = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;
  wire logic byte_done = (bit_cnt_reg == BITS_PER_BYTE);
  wire logic addr_match = (rx_shift_reg[7:1] == OWN_ADDR);
  wire logic [7:0] ptr_inc = reg_ptr_reg + 8'h01;

  // pin synchronisers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      slp_meta_reg <= 1'b0;
      slp_sync_reg <= 1'b0;
    end else begin
      scl_meta_reg <= bus_clock_pin_in;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= bus_data_pin_in;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
      slp_meta_reg <= sleep_in;
      slp_sync_reg <= slp_meta_reg;
    end
  end

  // next-state logic for the serial engine
  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    rx_shift_next = rx_shift_reg;
    tx_shift_next = tx_shift_reg;
    reg_ptr_next = reg_ptr_reg;
    master_ack_next = master_ack_reg;
    drive_low_next = drive_low_reg;
    busy_next = busy_reg;
    wr_en_next = 1'b0;
    wr_data_next = wr_data_reg;
    if (slp_sync_reg) begin
      // sleeping: core halted, line released, registers kept
      state_next = ST_IDLE;
      drive_low_next = 1'b0;
      busy_next = 1'b0;
    end else if (start_seen) begin
      // start or repeated start: same treatment
      state_next = ST_ADDR;
      bit_cnt_next = 4'h0;
      drive_low_next = 1'b0;
      busy_next = 1'b1;
    end else if (stop_seen) begin
      // stop: back to idle with the line released
      state_next = ST_IDLE;
      drive_low_next = 1'b0;
      busy_next = 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          // not addressed or a foreign address: stay released
          drive_low_next = 1'b0;
        end
        ST_ADDR, ST_REG, ST_WDATA: begin
          // receive: sample on rise, act on the fall after bit eight
          if (scl_rise && !byte_done) begin
            rx_shift_next = {rx_shift_reg[6:0], sda_sync_reg};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end else if (scl_fall && byte_done) begin
            bit_cnt_next = 4'h0;
            drive_low_next = 1'b1;
            if (state_reg == ST_ADDR) begin
              if (addr_match) begin
                state_next = ST_ADDR_ACK;
              end else begin
                state_next = ST_IDLE;
                drive_low_next = 1'b0;
              end
            end else if (state_reg == ST_REG) begin
              reg_ptr_next = rx_shift_reg;
              state_next = ST_REG_ACK;
            end else begin
              wr_en_next = 1'b1;
              wr_data_next = rx_shift_reg;
              state_next = ST_WACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          // end of address ack: become sender or receiver
          if (scl_fall) begin
            if (rx_shift_reg[0]) begin
              state_next = ST_RDATA;
              tx_shift_next = rf_rdata;
              drive_low_next = ~rf_rdata[7];
            end else begin
              state_next = ST_REG;
              drive_low_next = 1'b0;
            end
          end
        end
        ST_REG_ACK, ST_WACK: begin
          // ack clocked by the master, released on its fall
          if (scl_fall) begin
            state_next = ST_WDATA;
            drive_low_next = 1'b0;
            if (state_reg == ST_WACK) begin
              reg_ptr_next = ptr_inc;
            end
          end
        end
        ST_RDATA: begin
          // transmit: count on rise, shift on fall
          if (scl_rise) begin
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end else if (scl_fall && byte_done) begin
            bit_cnt_next = 4'h0;
            drive_low_next = 1'b0;
            reg_ptr_next = ptr_inc;
            state_next = ST_RACK;
          end else if (scl_fall) begin
            tx_shift_next = {tx_shift_reg[6:0], 1'b0};
            drive_low_next = ~tx_shift_reg[6];
          end
        end
        ST_RACK: begin
          // master answer: ack sends next byte, nack releases
          if (scl_rise) begin
            master_ack_next = ~sda_sync_reg;
          end else if (scl_fall) begin
            if (master_ack_reg) begin
              state_next = ST_RDATA;
              tx_shift_next = rf_rdata;
              drive_low_next = ~rf_rdata[7];
            end else begin
              state_next = ST_IDLE;
              drive_low_next = 1'b0;
            end
          end
        end
      endcase
    end
  end

  // serial engine registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      rx_shift_reg <= 8'h00;
      tx_shift_reg <= 8'h00;
      reg_ptr_reg <= 8'h00;
      master_ack_reg <= 1'b0;
      drive_low_reg <= 1'b0;
      busy_reg <= 1'b0;
      wr_en_reg <= 1'b0;
      wr_data_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      rx_shift_reg <= rx_shift_next;
      tx_shift_reg <= tx_shift_next;
      reg_ptr_reg <= reg_ptr_next;
      master_ack_reg <= master_ack_next;
      drive_low_reg <= drive_low_next;
      busy_reg <= busy_next;
      wr_en_reg <= wr_en_next;
      wr_data_reg <= wr_data_next;
    end
  end

  // analog power down follows the settled sleep level
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pd_reg <= 1'b0;
    end else begin
      pd_reg <= slp_sync_reg;
    end
  end

  // register storage and read port
  css_regfile u_regfile (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .wr_en_in(wr_en_reg),
    .addr_in(reg_ptr_reg),
    .wdata_in(wr_data_reg),
    .rdata_out(rf_rdata),
    .red_cap_out(red_capacitor_count_out),
    .green_cap_out(green_capacitor_count_out),
    .blue_cap_out(blue_capacitor_count_out),
    .clear_cap_out(clear_capacitor_count_out),
    .red_int_out(red_integration_slots_out),
    .green_int_out(green_integration_slots_out),
    .blue_int_out(blue_integration_slots_out),
    .clear_int_out(clear_integration_slots_out)
  );

  // open-drain data pin: only ever pulls low
  assign bus_data_pin_out = 1'b0;
  assign bus_data_pin_oe_out = drive_low_reg;
  assign bus_busy_out = busy_reg;
  assign analog_power_down_out = pd_reg;

endmodule : css_slave

`default_nettype wire

/* css_slave_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

// pin-level checks of the serial slave
module css_slave_assertions
  import css_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sleep_in,
  input wire logic bus_clock_pin_in,
  input wire logic bus_data_pin_in,
  input wire logic bus_data_pin_out,
  input wire logic bus_data_pin_oe_out,
  input wire logic bus_busy_out,
  input wire logic analog_power_down_out,
  input wire logic [CAP_W-1:0] red_capacitor_count_out,
  input wire logic [CAP_W-1:0] green_capacitor_count_out,
  input wire logic [CAP_W-1:0] blue_capacitor_count_out,
  input wire logic [CAP_W-1:0] clear_capacitor_count_out,
  input wire logic [INT_W-1:0] red_integration_slots_out,
  input wire logic [INT_W-1:0] green_integration_slots_out,
  input wire logic [INT_W-1:0] blue_integration_slots_out,
  input wire logic [INT_W-1:0] clear_integration_slots_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  // every gain setting in one word
  wire logic [63:0] gains = {red_capacitor_count_out, green_capacitor_count_out,
    blue_capacitor_count_out, clear_capacitor_count_out, red_integration_slots_out,
    green_integration_slots_out, blue_integration_slots_out, clear_integration_slots_out};

  // start and stop as seen on the pins
  sequence start_s;
    !sleep_in && bus_clock_pin_in && $fell(bus_data_pin_in);
  endsequence
  sequence stop_s;
    bus_clock_pin_in && $rose(bus_data_pin_in);
  endsequence

  idle_release_a:
    assert property (!bus_busy_out |-> !bus_data_pin_oe_out)
    else $error("data line driven while idle");
  data_stable_a:
    assert property ($changed(bus_data_pin_oe_out) && !sleep_in |-> !bus_clock_pin_in)
    else $error("data changed while clock high");
  busy_start_a:
    assert property (start_s |-> ##[1:6] bus_busy_out)
    else $error("start not seen");
  busy_stop_a:
    assert property (stop_s |-> ##[1:6] !bus_busy_out)
    else $error("stop not seen");
  pd_follow_a:
    assert property ($rose(sleep_in) |-> ##[1:6] analog_power_down_out)
    else $error("power down missing");
  sleep_idle_a:
    assert property (analog_power_down_out && $past(analog_power_down_out)
      |-> !bus_busy_out && !bus_data_pin_oe_out)
    else $error("bus active while asleep");
  regs_quiet_a:
    assert property (!bus_busy_out |-> $stable(gains))
    else $error("gain changed without transfer");
  reset_values_a:
    assert property (disable iff (1'b0) rst_in && $past(rst_in)
      |-> gains == {{4{4'hF}}, 48'h0000_0000_0000})
    else $error("gain reset value wrong");
endmodule : css_slave_assertions

bind css_slave css_slave_assertions u_css_slave_assertions (
  .clk_in, .rst_in, .sleep_in, .bus_clock_pin_in, .bus_data_pin_in,
  .bus_data_pin_out, .bus_data_pin_oe_out, .bus_busy_out, .analog_power_down_out,
  .red_capacitor_count_out, .green_capacitor_count_out, .blue_capacitor_count_out,
  .clear_capacitor_count_out, .red_integration_slots_out, .green_integration_slots_out,
  .blue_integration_slots_out, .clear_integration_slots_out
);

`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none

// self-checking bench, the master model drives the serial pins
module testbench
  import css_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic sleep_in = 1'b0;
  logic scl, m_sda, oe, dout, busy, pd;
  logic [CAP_W-1:0] cap_o [4];
  logic [INT_W-1:0] slot_o [4];
  integer seed = 32'he464_83b8;
  int bad_count = 0;
  int total_checks = 0;
  // offsets per channel: red, green, blue, clear
  localparam logic [7:0] CAP_TAB [4] = '{RED_CAP_OFS, GREEN_CAP_OFS, BLUE_CAP_OFS, CLEAR_CAP_OFS};
  localparam logic [7:0] SLOT_TAB [4] = '{RED_INT_OFS, GREEN_INT_OFS, BLUE_INT_OFS, CLEAR_INT_OFS};
  // open-drain data wire with pull-up
  wire logic sda_w = (oe ? dout : 1'b1) & m_sda;

  // 250 MHz core clock
  always #2 clk_in = ~clk_in;

  css_slave u_css_slave (
    .clk_in, .rst_in, .sleep_in, .bus_clock_pin_in(scl), .bus_data_pin_in(sda_w),
    .bus_data_pin_out(dout), .bus_data_pin_oe_out(oe), .bus_busy_out(busy),
    .analog_power_down_out(pd), .red_capacitor_count_out(cap_o[0]),
    .green_capacitor_count_out(cap_o[1]), .blue_capacitor_count_out(cap_o[2]),
    .clear_capacitor_count_out(cap_o[3]), .red_integration_slots_out(slot_o[0]),
    .green_integration_slots_out(slot_o[1]), .blue_integration_slots_out(slot_o[2]),
    .clear_integration_slots_out(slot_o[3])
  );
  css_mst u_css_mst (.clk_in, .sda_in(sda_w), .scl_out(scl), .sda_out(m_sda));

  // low nibble of a byte, as a byte register reads back
  function automatic logic [11:0] nib_exp(input logic [7:0] v);
    return {8'h00, v[3:0]};
  endfunction : nib_exp
  // twelve-bit slot count from its two halves
  function automatic logic [11:0] slot_exp(input logic [7:0] lo, input logic [7:0] hi);
    return {hi[3:0], lo};
  endfunction : slot_exp

  task automatic chk_val(input string what, input logic [11:0] exp, input logic [11:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val
  task automatic chk_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  // counts, verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  // register access: pointer write, then data write or restart and read
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic rd,
                      output logic [7:0] r);
    logic k;
    r = 8'h00;
    u_css_mst.start();
    u_css_mst.wr_byte({OWN_ADDR, 1'b0}, k);
    chk_bit("address ack", 1'b1, k);
    chk_bit("busy", 1'b1, busy);
    u_css_mst.wr_byte(a, k);
    chk_bit("register ack", 1'b1, k);
    if (rd) begin
      u_css_mst.start();
      u_css_mst.wr_byte({OWN_ADDR, 1'b1}, k);
      chk_bit("read address ack", 1'b1, k);
      u_css_mst.rd_byte(1'b1, r);
    end else begin
      u_css_mst.wr_byte(d, k);
      chk_bit("data ack", 1'b1, k);
    end
    u_css_mst.stop();
    repeat (4) @(posedge clk_in);
    chk_bit("bus free", 1'b0, busy);
  endtask : xfer

  // reset values on the ports and over the bus
  task automatic chk_defaults();
    logic [7:0] r;
    for (int i = 0; i < 4; i++) begin
      chk_val("cap reset", 12'h00F, 12'(cap_o[i]));
      chk_val("slot reset", 12'h000, slot_o[i]);
    end
    xfer(RED_CAP_OFS, 8'h00, 1'b1, r);
    chk_val("cap reset read", 12'h00F, 12'(r));
  endtask : chk_defaults

  initial begin
    logic [7:0] v, h, r;
    logic [6:0] fa;
    logic k;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    chk_defaults();
    $display("test reset done");
    // capacitor counts, the last at its top value
    for (int i = 0; i < 4; i++) begin
      v = (i == 3) ? 8'hFF : 8'($random(seed));
      xfer(CAP_TAB[i], v, 1'b0, r);
      xfer(CAP_TAB[i], 8'h00, 1'b1, r);
      chk_val("cap read", nib_exp(v), 12'(r));
      chk_val("cap port", nib_exp(v), 12'(cap_o[i]));
    end
    $display("test capacitors done");
    // slot counts, the first at FFF
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'hFF : 8'($random(seed));
      h = (i == 0) ? 8'hFF : 8'($random(seed));
      xfer(SLOT_TAB[i], v, 1'b0, r);
      xfer(SLOT_TAB[i] + HIGH_BYTE_STEP, h, 1'b0, r);
      xfer(SLOT_TAB[i] + HIGH_BYTE_STEP, 8'h00, 1'b1, r);
      chk_val("slot high read", nib_exp(h), 12'(r));
      chk_val("slot port", slot_exp(v, h), slot_o[i]);
    end
    // bursts: pointer steps after each byte, master acks all but the last
    v = 8'($random(seed));
    h = 8'($random(seed));
    for (int j = 0; j < 2; j++) begin
      u_css_mst.start();
      u_css_mst.wr_byte({OWN_ADDR, 1'b0}, k);
      u_css_mst.wr_byte(GREEN_INT_OFS, k);
      if (j == 0) begin
        u_css_mst.wr_byte(v, k);
        u_css_mst.wr_byte(h, k);
        chk_bit("burst ack", 1'b1, k);
      end else begin
        u_css_mst.start();
        u_css_mst.wr_byte({OWN_ADDR, 1'b1}, k);
        u_css_mst.rd_byte(1'b0, r);
        chk_val("burst low read", 12'(v), 12'(r));
        u_css_mst.rd_byte(1'b1, r);
        chk_val("burst high read", nib_exp(h), 12'(r));
      end
      u_css_mst.stop();
    end
    chk_val("burst port", slot_exp(v, h), slot_o[1]);
    xfer(8'h20, 8'h5A, 1'b0, r);
    xfer(8'h20, 8'h00, 1'b1, r);
    chk_val("unmapped read", 12'h000, 12'(r));
    $display("test slots done");
    // foreign addresses, one next to ours, both directions
    for (int i = 0; i < 2; i++) begin
      fa = (i == 0) ? (OWN_ADDR ^ 7'h01) : 7'($random(seed));
      if (fa == OWN_ADDR) fa = 7'h00;
      u_css_mst.start();
      u_css_mst.wr_byte({fa, i[0]}, k);
      chk_bit("foreign ack", 1'b0, k);
      u_css_mst.wr_byte(RED_CAP_OFS, k);
      chk_bit("ignored ack", 1'b0, k);
      u_css_mst.stop();
    end
    $display("test foreign done");
    // sleep: powered down, bus ignored
    sleep_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    chk_bit("power down", 1'b1, pd);
    u_css_mst.start();
    u_css_mst.wr_byte({OWN_ADDR, 1'b0}, k);
    chk_bit("asleep ack", 1'b0, k);
    u_css_mst.stop();
    sleep_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    chk_bit("power up", 1'b0, pd);
    $display("test sleep done");
    // second reset in mid-run
    rst_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    chk_defaults();
    $display("test second reset done");
    test_done();
  end

  // hang guard, about three times the expected run
  initial begin
    #200000;
    bad_count++;
    test_done();
  end
endmodule : testbench

`default_nettype wire
